// ---- pkg/rtcd_pkg.sv ----
// package for the rmap target command dispatch block
package rtcd_pkg;
  localparam logic [7:0] RTCD_PROTO_RMAP = 8'h01;
  localparam logic [1:0] RTCD_TYPE_CMD = 2'h1;
  localparam int RTCD_BIT_WRITE = 5;
  localparam int RTCD_BIT_VERIFY = 4;
  localparam int RTCD_BIT_ACK = 3;
  localparam int RTCD_BIT_INC = 2;
  localparam logic [7:0] RTCD_ERR_NONE = 8'h00;
  localparam logic [7:0] RTCD_ERR_GENERAL = 8'h01;
  localparam logic [7:0] RTCD_ERR_UNUSED = 8'h02;
  localparam logic [7:0] RTCD_ERR_KEY = 8'h03;
  localparam logic [7:0] RTCD_ERR_VERIFY_OVR = 8'h09;
  localparam logic [7:0] RTCD_ERR_AUTH = 8'h0A;
  localparam logic [7:0] RTCD_ERR_RMW_LEN = 8'h0B;
  localparam int RTCD_REPLY_DEPTH = 4;
  localparam int RTCD_CNT_W = 3;
  localparam logic [1:0] RTCD_ADDR_CTRL = 2'h0;
  localparam logic [1:0] RTCD_ADDR_KEY = 2'h1;
  localparam logic [1:0] RTCD_ADDR_STAT = 2'h2;
  localparam int RTCD_CTRL_EN = 0;
  localparam int RTCD_CTRL_RBD = 1;
  localparam logic [1:0] RTCD_CTRL_RST = 2'h0;
  localparam logic [7:0] RTCD_KEY_RST = 8'h00;
  typedef enum logic [1:0] {
    RTCD_ACT_DMA = 2'h0, RTCD_ACT_DROP = 2'h1, RTCD_ACT_EXEC = 2'h3, RTCD_ACT_REJECT = 2'h2
  } rtcd_act_type;
  typedef enum logic [1:0] {
    RTCD_OP_NONE = 2'h0, RTCD_OP_READ = 2'h1, RTCD_OP_WRITE = 2'h3, RTCD_OP_RMW = 2'h2
  } rtcd_op_type;
  typedef struct packed {
    logic [7:0] proto;
    logic [7:0] cmd;
    logic [7:0] key;
    logic [31:0] addr;
    logic [23:0] len;
  } rtcd_hdr_type;
  typedef struct packed {
    rtcd_act_type act;
    rtcd_op_type op;
    logic reply;
    logic inc;
    logic [7:0] err;
  } rtcd_dec_type;
endpackage

// ---- hdl/rtcd_check.sv ----
// pure decoder: command bits, size and alignment checks
`timescale 1ns/100ps
`default_nettype none
module rtcd_check import rtcd_pkg::*; (
  // header in
  input wire rtcd_hdr_type hdr,
  input wire logic [7:0] exp_key,
  input wire logic enable,
  // decision out
  output rtcd_dec_type dec
);
  logic wr, vf, ack, inc, word_ok, len4_ok, rmw_al_ok, vw_al_ok;
  logic [23:0] half;
  always_comb begin
    wr = hdr.cmd[RTCD_BIT_WRITE];
    vf = hdr.cmd[RTCD_BIT_VERIFY];
    ack = hdr.cmd[RTCD_BIT_ACK];
    inc = hdr.cmd[RTCD_BIT_INC];
    word_ok = (hdr.addr[1:0] == 2'h0) && (hdr.len[1:0] == 2'h0);
    len4_ok = (hdr.len != 24'h000000) && (hdr.len <= 24'h000004);
    half = hdr.len >> 1;
    rmw_al_ok = (half == 24'h000001) || ((half == 24'h000002) && !hdr.addr[0])
      || ((half == 24'h000004) && (hdr.addr[1:0] == 2'h0));
    vw_al_ok = (hdr.len == 24'h000001) || ((hdr.len == 24'h000002) && !hdr.addr[0])
      || ((hdr.len == 24'h000004) && (hdr.addr[1:0] == 2'h0));
    dec.act = RTCD_ACT_EXEC;
    dec.op = RTCD_OP_NONE;
    dec.reply = ack; // reply iff ack, unless routed to dma or dropped
    dec.inc = inc;
    dec.err = RTCD_ERR_NONE;
    if (!enable || hdr.proto != RTCD_PROTO_RMAP || hdr.cmd[7:6] != RTCD_TYPE_CMD) begin
      dec.act = RTCD_ACT_DMA;
      dec.reply = 1'b0;
    end else if (!wr && !ack) begin
      dec.act = RTCD_ACT_DROP;
    end else if (!wr && vf && !inc) begin
      dec.act = RTCD_ACT_REJECT;
      dec.err = RTCD_ERR_UNUSED;
    end else if (ack && hdr.key != exp_key) begin
      dec.act = RTCD_ACT_REJECT;
      dec.err = RTCD_ERR_KEY;
    end else if (!wr && vf) begin
      dec.op = RTCD_OP_RMW;
      if (!(hdr.len == 24'h2 || hdr.len == 24'h4 || hdr.len == 24'h8)) begin
        dec.act = RTCD_ACT_REJECT;
        dec.err = RTCD_ERR_RMW_LEN;
      end else if (!rmw_al_ok) begin
        dec.act = RTCD_ACT_REJECT;
        dec.err = RTCD_ERR_AUTH;
      end
    end else if (!wr) begin
      dec.op = RTCD_OP_READ;
      if (!inc && !word_ok) begin
        dec.act = RTCD_ACT_REJECT;
        dec.err = RTCD_ERR_AUTH;
      end // incrementing read unrestricted
    end else if (vf) begin
      dec.op = RTCD_OP_WRITE;
      if (!len4_ok) begin
        dec.act = ack ? RTCD_ACT_REJECT : RTCD_ACT_DROP;
        dec.err = RTCD_ERR_VERIFY_OVR;
      end else if (!vw_al_ok) begin
        dec.act = ack ? RTCD_ACT_REJECT : RTCD_ACT_DROP;
        dec.err = RTCD_ERR_AUTH;
      end
    end else begin
      dec.op = RTCD_OP_WRITE;
      if (!inc && !word_ok) begin
        dec.act = ack ? RTCD_ACT_REJECT : RTCD_ACT_DROP;
        dec.err = ack ? RTCD_ERR_AUTH : RTCD_ERR_NONE;
      end // incrementing write unrestricted
    end
    if (dec.act == RTCD_ACT_DROP) begin
      dec.op = RTCD_OP_NONE;
      dec.reply = 1'b0;
    end
    if (dec.act == RTCD_ACT_REJECT) begin
      dec.op = RTCD_OP_NONE;
    end
  end
endmodule // rtcd_check
`default_nettype wire

// ---- hdl/rtcd_top.sv ----
// rmap target command dispatch: decode, execute control, reply slots
// Notes on behaviour
// - only protocol one, type 01 handled
// - disabled handler sends all to DMA
// - several reply slots; reads fetched at send
// - buffer disable limits to one slot
// - software destination key checked on commands with ack
// - read without ack: nothing, no reply
// - single read aligned, else error 10
// - incrementing read with ack unrestricted
// - verify read single: error 2 reply
// - bad rmw length: error 11
// - rmw misaligned: error 10
// - bus error on write/rmw: error 1
// - single write no ack: aligned or dropped
// - incrementing write no ack: unrestricted, silent
// - single write with ack: misaligned error 10
`timescale 1ns/100ps
`default_nettype none
module rtcd_top import rtcd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // packet header from receiver
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire rtcd_hdr_type hdr,
  // routing result
  output logic to_dma,
  output logic to_drop,
  // bus operation request
  output logic op_valid,
  input wire logic op_ready,
  output rtcd_op_type op_kind,
  output logic [31:0] op_addr,
  output logic [23:0] op_len,
  output logic op_inc,
  input wire logic op_done,
  input wire logic op_bus_err,
  // reply to transmitter
  output logic rep_valid,
  input wire logic rep_ready,
  output logic [7:0] rep_err,
  output logic rep_is_read,
  output logic [31:0] rep_addr,
  output logic [23:0] rep_len,
  output logic rep_inc
);
  typedef enum logic [1:0] {
    RTCD_ST_IDLE = 2'h0, RTCD_ST_ISSUE = 2'h1, RTCD_ST_WAIT = 2'h3
  } rtcd_st_type;

  typedef struct packed {
    logic [7:0] err;
    logic is_read;
    logic [31:0] addr;
    logic [23:0] len;
    logic inc;
  } rtcd_slot_type;

  rtcd_dec_type dec;
  rtcd_st_type st_reg, st_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [7:0] key_reg, key_next;
  logic [31:0] rdata_reg, rdata_next;
  rtcd_hdr_type cur_reg, cur_next;
  logic cur_reply_reg, cur_reply_next;
  logic dma_reg, dma_next, drop_reg, drop_next;
  rtcd_slot_type slot_reg [RTCD_REPLY_DEPTH];
  rtcd_slot_type slot_next [RTCD_REPLY_DEPTH];
  logic [1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [RTCD_CNT_W-1:0] cnt_reg, cnt_next;
  logic [RTCD_CNT_W-1:0] limit;
  logic room, push, pop, take;
  rtcd_slot_type push_slot;
  rtcd_op_type cur_op_reg, cur_op_next;

  rtcd_check u_check (
    .hdr(hdr),
    .exp_key(key_reg),
    .enable(ctrl_reg[RTCD_CTRL_EN]),
    .dec(dec)
  );

  // reply slot admission
  always_comb begin
    limit = ctrl_reg[RTCD_CTRL_RBD] ? RTCD_CNT_W'(1) : RTCD_CNT_W'(RTCD_REPLY_DEPTH);
    room = cnt_reg < limit;
  end

  // header accept: commands that may reply wait for a free slot
  always_comb begin
    hdr_ready = (st_reg == RTCD_ST_IDLE) && (room || dec.act == RTCD_ACT_DMA
      || dec.act == RTCD_ACT_DROP);
    take = hdr_valid && hdr_ready;
  end

  // register port
  always_comb begin
    ctrl_next = ctrl_reg;
    key_next = key_reg;
    rdata_next = 32'h00000000;
    if (reg_wr && reg_addr == RTCD_ADDR_CTRL) begin
      ctrl_next = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == RTCD_ADDR_KEY) begin
      key_next = reg_wdata[7:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        RTCD_ADDR_CTRL: rdata_next = {30'h0, ctrl_reg};
        RTCD_ADDR_KEY: rdata_next = {24'h0, key_reg};
        RTCD_ADDR_STAT: rdata_next = {27'h0, st_reg, cnt_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // command sequencer
  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    cur_reply_next = cur_reply_reg;
    cur_op_next = cur_op_reg;
    dma_next = 1'b0;
    drop_next = 1'b0;
    push = 1'b0;
    push_slot = '0;
    case (st_reg)
      RTCD_ST_IDLE: begin
        if (take) begin
          case (dec.act)
            RTCD_ACT_DMA: dma_next = 1'b1;
            RTCD_ACT_DROP: drop_next = 1'b1;
            RTCD_ACT_REJECT: begin
              drop_next = 1'b1;
              push = dec.reply;
              push_slot = '{err: dec.err, is_read: 1'b0, addr: hdr.addr, len: hdr.len,
                inc: dec.inc};
            end
            RTCD_ACT_EXEC: begin
              cur_next = hdr;
              cur_reply_next = dec.reply;
              cur_op_next = dec.op;
              if (dec.op == RTCD_OP_READ) begin
                push = 1'b1;
                push_slot = '{err: RTCD_ERR_NONE, is_read: 1'b1, addr: hdr.addr,
                  len: hdr.len, inc: dec.inc};
              end else begin
                st_next = RTCD_ST_ISSUE;
              end
            end
            default: drop_next = 1'b1;
          endcase
        end
      end
      RTCD_ST_ISSUE: begin
        if (op_ready) begin
          st_next = RTCD_ST_WAIT;
        end
      end
      RTCD_ST_WAIT: begin
        if (op_done) begin
          st_next = RTCD_ST_IDLE;
          push = cur_reply_reg;
          push_slot = '{err: op_bus_err ? RTCD_ERR_GENERAL : RTCD_ERR_NONE,
            is_read: 1'b0, addr: cur_reg.addr, len: cur_reg.len,
            inc: cur_reg.cmd[RTCD_BIT_INC]};
        end
      end
      default: st_next = RTCD_ST_IDLE;
    endcase
  end

  // reply slot ring
  always_comb begin
    pop = rep_valid && rep_ready;
    for (int i = 0; i < RTCD_REPLY_DEPTH; i++) begin
      slot_next[i] = slot_reg[i];
    end
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push) begin
      slot_next[wp_reg] = push_slot;
      wp_next = wp_reg + 2'h1;
    end
    if (pop) begin
      rp_next = rp_reg + 2'h1;
    end
    cnt_next = cnt_reg + RTCD_CNT_W'(push) - RTCD_CNT_W'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= RTCD_ST_IDLE;
      ctrl_reg <= RTCD_CTRL_RST;
      key_reg <= RTCD_KEY_RST;
      rdata_reg <= 32'h00000000;
      cur_reg <= '0;
      cur_reply_reg <= 1'b0;
      cur_op_reg <= RTCD_OP_NONE;
      dma_reg <= 1'b0;
      drop_reg <= 1'b0;
      wp_reg <= 2'h0;
      rp_reg <= 2'h0;
      cnt_reg <= '0;
      for (int i = 0; i < RTCD_REPLY_DEPTH; i++) begin
        slot_reg[i] <= '0;
      end
    end else begin
      st_reg <= st_next;
      ctrl_reg <= ctrl_next;
      key_reg <= key_next;
      rdata_reg <= rdata_next;
      cur_reg <= cur_next;
      cur_reply_reg <= cur_reply_next;
      cur_op_reg <= cur_op_next;
      dma_reg <= dma_next;
      drop_reg <= drop_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      for (int i = 0; i < RTCD_REPLY_DEPTH; i++) begin
        slot_reg[i] <= slot_next[i];
      end
    end
  end

  // outputs
  always_comb begin
    reg_rdata = rdata_reg;
    to_dma = dma_reg;
    to_drop = drop_reg;
    op_valid = (st_reg == RTCD_ST_ISSUE);
    op_kind = cur_op_reg;
    op_addr = cur_reg.addr;
    op_len = cur_reg.len;
    op_inc = cur_reg.cmd[RTCD_BIT_INC];
    rep_valid = (cnt_reg != '0);
    rep_err = slot_reg[rp_reg].err;
    rep_is_read = slot_reg[rp_reg].is_read;
    rep_addr = slot_reg[rp_reg].addr;
    rep_len = slot_reg[rp_reg].len;
    rep_inc = slot_reg[rp_reg].inc;
  end

  AST_RBD_ONE_SLOT: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[RTCD_CTRL_RBD] && cnt_reg >= 3'h1 && !$past(!ctrl_reg[RTCD_CTRL_RBD])
      |-> !(take && dec.reply && dec.act != RTCD_ACT_DMA))
    else $error("second reply slot used while buffer disabled");
  AST_DISABLED_DMA: assert property (@(posedge clk) disable iff (!rst_n)
    take && !ctrl_reg[RTCD_CTRL_EN] |=> to_dma && !to_drop)
    else $error("disabled handler did not route to dma");
  AST_NONCMD_DMA: assert property (@(posedge clk) disable iff (!rst_n)
    take && hdr.cmd[7:6] != RTCD_TYPE_CMD |=> to_dma)
    else $error("non-command packet not routed to dma");
  AST_READ_NOACK: assert property (@(posedge clk) disable iff (!rst_n)
    take && ctrl_reg[RTCD_CTRL_EN] && hdr.proto == RTCD_PROTO_RMAP
      && hdr.cmd[7:6] == RTCD_TYPE_CMD && hdr.cmd[5] == 1'b0 && hdr.cmd[3] == 1'b0
      |=> to_drop && cnt_reg == $past(cnt_reg) - 3'($past(pop)))
    else $error("read without ack was not dropped");
  AST_BUS_ERR: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg == RTCD_ST_WAIT && op_done && op_bus_err && cur_reply_reg
      |=> slot_reg[$past(wp_reg)].err == RTCD_ERR_GENERAL)
    else $error("bus error not reported as code 1");
  AST_OP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid && !op_ready |=> op_valid && $stable(op_addr))
    else $error("operation request dropped before taken");
  AST_KEY_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == RTCD_ADDR_KEY |=> key_reg == $past(reg_wdata[7:0]))
    else $error("destination key not stored");
  AST_CNT_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_reg <= 3'h4)
    else $error("reply slot count out of range");
endmodule // rtcd_top
`default_nettype wire

// ---- testbench/rtcd_bus_model.sv ----
// bus slave model answering operation requests
`timescale 1ns/100ps
`default_nettype none
module rtcd_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench control
  input wire logic slow,
  input wire logic err_mode,
  // operation port
  input wire logic op_valid,
  output logic op_ready,
  output logic op_done,
  output logic op_bus_err
);
  logic [3:0] cnt;
  logic busy;
  always_ff @(posedge clk) begin
    op_ready <= 1'h0;
    op_done <= 1'h0;
    // error line means nothing outside op_done
    op_bus_err <= ~op_bus_err;
    if (!rst_n) begin
      busy <= 1'h0;
      cnt <= 4'h0;
      op_bus_err <= 1'h0;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0) begin
        busy <= 1'h0;
        op_done <= 1'h1;
        op_bus_err <= err_mode;
      end
    end else if (op_valid && !op_ready) begin
      op_ready <= 1'h1;
      busy <= 1'h1;
      cnt <= slow ? 4'h6 : 4'h0;
    end
  end
endmodule // rtcd_bus_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the command dispatch block
`timescale 1ns/100ps
`default_nettype none
module tb_top import rtcd_pkg::*;;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic hdr_valid = 1'h0;
  rtcd_hdr_type hdr = '0;
  logic rep_ready = 1'h0;
  logic slow = 1'h0;
  logic err_mode = 1'h0;
  logic [7:0] pkt_key = 8'h5A;
  logic [31:0] reg_rdata, op_addr, rep_addr, rd;
  logic hdr_ready, to_dma, to_drop, op_valid, op_ready, op_inc, op_done, op_bus_err;
  logic rep_valid, rep_is_read, rep_inc;
  logic [23:0] op_len, rep_len;
  logic [7:0] rep_err;
  rtcd_op_type op_kind;
  int n_fail = 0;
  int samples_checked = 0;
  initial forever #10 clk = ~clk;
  rtcd_top u_rtcd_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr(hdr), .to_dma(to_dma), .to_drop(to_drop), .op_valid(op_valid),
    .op_ready(op_ready), .op_kind(op_kind), .op_addr(op_addr), .op_len(op_len),
    .op_inc(op_inc), .op_done(op_done), .op_bus_err(op_bus_err), .rep_valid(rep_valid),
    .rep_ready(rep_ready), .rep_err(rep_err), .rep_is_read(rep_is_read),
    .rep_addr(rep_addr), .rep_len(rep_len), .rep_inc(rep_inc));
  rtcd_bus_model u_rtcd_bus_model (.clk(clk), .rst_n(rst_n), .slow(slow),
    .err_mode(err_mode), .op_valid(op_valid), .op_ready(op_ready), .op_done(op_done),
    .op_bus_err(op_bus_err));
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tally(string nm, logic ok, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic g);
    tally(nm, g === e, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] g);
    tally(nm, g === e, {24'h0, e}, {24'h0, g});
  endtask
  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    tally(nm, g === e, e, g);
  endtask
  // 0 header ready, 1 operation done, 2 reply pending
  task automatic wait_for(int which);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if ((which == 0 && hdr_ready === 1'h1) || (which == 1 && op_done === 1'h1) ||
          (which == 2 && rep_valid === 1'h1)) return;
    end
    tally("wait", 1'h0, 32'h1, which);
    final_report();
  endtask
  task automatic reg_write(logic [1:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_read(logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    rd = reg_rdata;
  endtask
  task automatic offer(logic [7:0] p, logic [7:0] c, logic [31:0] a, logic [23:0] l);
    @(posedge clk);
    hdr <= '{p, c, pkt_key, a, l};
    hdr_valid <= 1'h1;
  endtask
  task automatic take();
    wait_for(0);
    @(posedge clk);
    hdr_valid <= 1'h0;
    hdr <= ~hdr;
    @(negedge clk);
  endtask
  task automatic pop();
    @(posedge clk);
    rep_ready <= 1'h1;
    @(posedge clk);
    rep_ready <= 1'h0;
  endtask
  // kind: 0 dma, 1 drop, 2 reply only, 3 bus operation
  task automatic run(logic [7:0] c, logic [31:0] a, logic [23:0] l, int kind, logic [7:0] e);
    offer(RTCD_PROTO_RMAP, c, a, l);
    take();
    cmp_bit("to_dma", kind == 0, to_dma);
    // a refused command executes nothing, so it counts as dropped
    cmp_bit("to_drop", kind == 1 || (kind == 2 && e != 8'h0), to_drop);
    cmp_bit("op_valid", kind == 3, op_valid);
    if (kind == 3) begin
      cmp_word("op_addr", a, op_addr);
      cmp_word("op_len", {8'h0, l}, {8'h0, op_len});
      cmp_bit("op_inc", c[RTCD_BIT_INC], op_inc);
      cmp_byte("op_kind", {6'h0, c[5] ? RTCD_OP_WRITE : RTCD_OP_RMW}, {6'h0, op_kind});
      wait_for(1);
    end
    if (kind >= 2 && c[RTCD_BIT_ACK]) begin
      wait_for(2);
      cmp_byte("rep_err", e, rep_err);
      if (!c[4] && (c[5] || e == 8'h0)) cmp_bit("rep_is_read", !c[5], rep_is_read);
      cmp_word("rep_addr", a, rep_addr);
      cmp_word("rep_len", {8'h0, l}, {8'h0, rep_len});
      cmp_bit("rep_inc", c[RTCD_BIT_INC], rep_inc);
      pop();
    end else begin
      repeat (3) @(negedge clk);
      cmp_bit("rep_valid", 1'h0, rep_valid);
    end
  endtask
  task automatic t_regs();
    reg_read(RTCD_ADDR_CTRL);
    cmp_word("ctrl", 32'h0, rd);
    reg_read(RTCD_ADDR_KEY);
    cmp_word("key", 32'h0, rd);
    reg_write(RTCD_ADDR_KEY, 32'h5A);
    reg_read(RTCD_ADDR_KEY);
    cmp_word("key", 32'h5A, rd);
    reg_write(2'h3, 32'hFFFFFFFF);
    reg_read(2'h3);
    cmp_word("unmapped", 32'h0, rd);
  endtask
  task automatic t_route();
    run(8'h4C, 32'h0, 24'h4, 0, 8'h0);
    reg_write(RTCD_ADDR_CTRL, 32'h1);
    offer(8'h02, 8'h4C, 32'h0, 24'h4);
    take();
    cmp_bit("to_dma", 1'h1, to_dma);
    run(8'h0C, 32'h0, 24'h4, 0, 8'h0);
    run(8'h8C, 32'h0, 24'h4, 0, 8'h0);
    run(8'hCC, 32'h0, 24'h4, 0, 8'h0);
    pkt_key = 8'h33;
    run(8'h4C, 32'h0, 24'h4, 2, RTCD_ERR_KEY);
    pkt_key = 8'h5A;
  endtask
  task automatic t_reads();
    for (int i = 0; i < 4; i++) run({3'h2, i[1], 1'h0, i[0], 2'h0}, 0, 4, 1, 0);
    run(8'h48, 32'h100, 24'h8, 2, RTCD_ERR_NONE);
    run(8'h48, 32'h102, 24'h8, 2, RTCD_ERR_AUTH);
    run(8'h48, 32'h100, 24'h6, 2, RTCD_ERR_AUTH);
    run(8'h4C, 32'h103, 24'h5, 2, RTCD_ERR_NONE);
    run(8'h58, 32'h100, 24'h4, 2, RTCD_ERR_UNUSED);
  endtask
  task automatic t_rmw();
    run(8'h5C, 32'h100, 24'h6, 2, RTCD_ERR_RMW_LEN);
    run(8'h5C, 32'h100, 24'h3, 2, RTCD_ERR_RMW_LEN);
    run(8'h5C, 32'h101, 24'h4, 2, RTCD_ERR_AUTH);
    run(8'h5C, 32'h102, 24'h8, 2, RTCD_ERR_AUTH);
    run(8'h5C, 32'h103, 24'h2, 3, RTCD_ERR_NONE);
    slow = 1'h1;
    run(8'h5C, 32'h102, 24'h4, 3, RTCD_ERR_NONE);
    err_mode = 1'h1;
    run(8'h5C, 32'h100, 24'h8, 3, RTCD_ERR_GENERAL);
    run(8'h6C, 32'h101, 24'h3, 3, RTCD_ERR_GENERAL);
    err_mode = 1'h0;
    slow = 1'h0;
  endtask
  task automatic t_writes();
    run(8'h60, 32'h100, 24'h8, 3, 8'h0);
    run(8'h60, 32'h102, 24'h8, 1, 8'h0);
    run(8'h60, 32'h100, 24'h6, 1, 8'h0);
    run(8'h64, 32'h101, 24'h3, 3, 8'h0);
    run(8'h68, 32'h102, 24'h8, 2, RTCD_ERR_AUTH);
    run(8'h68, 32'h100, 24'h5, 2, RTCD_ERR_AUTH);
    run(8'h68, 32'h100, 24'h8, 3, RTCD_ERR_NONE);
    // verified writes: at most four bytes, aligned to their size
    run(8'h78, 32'h100, 24'h5, 2, RTCD_ERR_VERIFY_OVR);
    run(8'h7C, 32'h100, 24'h3, 2, RTCD_ERR_AUTH);
    run(8'h78, 32'h102, 24'h2, 3, RTCD_ERR_NONE);
    run(8'h70, 32'h101, 24'h4, 1, 8'h0);
  endtask
  // replies held back until slots fill; then drained
  task automatic fill_check(int n);
    for (int i = 0; i < n; i++) begin
      offer(RTCD_PROTO_RMAP, 8'h4C, 32'h200, 24'h4);
      take();
    end
    offer(RTCD_PROTO_RMAP, 8'h4C, 32'h200, 24'h4);
    repeat (3) @(negedge clk);
    cmp_bit("hdr_ready", 1'h0, hdr_ready);
    pop();
    take();
    @(posedge clk);
    rep_ready <= 1'h1;
    repeat (8) @(posedge clk);
    rep_ready <= 1'h0;
    @(negedge clk);
    cmp_bit("rep_valid", 1'h0, rep_valid);
  endtask
  task automatic t_buffer();
    offer(RTCD_PROTO_RMAP, 8'h4C, 32'h200, 24'h4);
    take();
    offer(RTCD_PROTO_RMAP, 8'h64, 32'h200, 24'h4);
    take();
    cmp_bit("op_valid", 1'h1, op_valid);
    wait_for(1);
    fill_check(3);
    reg_write(RTCD_ADDR_CTRL, 32'h3);
    fill_check(1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_route();
    t_reads();
    t_rmw();
    t_writes();
    t_buffer();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
